// >>> dv/line_sync_fieldbus_words_bench.sv
// Self-checking bench for the line sync word engine.
// Assumes design, package, master model and checker compiled before.
`timescale 1ns/100ps
module line_sync_fieldbus_words_bench;
    import lsf_pkg::*;
    logic        clk, rst_n, clk_en, main_status_valid;
    logic [15:0] sync_control_word, main_drive_status, sync_status_word;
    logic [7:0]  status_select_param;
    logic        grid_ref_sel, angle_align, close_line_cmd, flying_start;
    logic        converter_relay_drive, line_relay_drive, start_edge_req;
    logic [2:0]  motor_sel;
    lsf_drive_t  drive;
    lsf_meas_t   meas;
    int          miscompares, num_checks;
    lsf_word_engine dut (.clk, .rst_n, .clk_en, .sync_control_word,
        .status_select_param, .main_drive_status, .sync_status_word,
        .main_status_valid, .drive, .meas, .grid_ref_sel, .angle_align,
        .close_line_cmd, .converter_relay_drive, .line_relay_drive,
        .flying_start, .start_edge_req, .motor_sel);
    lsf_fieldbus_master fb (.clk, .sync_status_word, .sync_control_word,
        .status_select_param);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Field order of the struct is reversed on the wire
    task automatic t_status;
        fb.select(8'h40);
        step(1);
        chk(main_drive_status, 16'h052D);
        chk({15'h0, main_status_valid}, 16'h0001);
        chk(sync_status_word, 16'h1049);
        drive = lsf_drive_t'(11'h25A);
        fb.select(8'h41);
        step(1);
        chk(main_drive_status, 16'h02D2);
        chk({15'h0, main_status_valid}, 16'h0000);
    endtask
    task automatic t_drop;
        fb.send(16'h8888);
        step(2);
        chk({15'h0, grid_ref_sel}, 16'h0000);
        fb.send(16'h0001);
        step(1);
        chk({15'h0, grid_ref_sel}, 16'h0001);
        fb.send(16'h0000);
        step(1);
        chk({15'h0, grid_ref_sel}, 16'h0000);
    endtask
    // Frozen enable holds the request back until it rises
    task automatic t_freeze;
        clk_en = 1'b0;
        fb.send(16'h0001);
        step(2);
        chk({14'h0, grid_ref_sel, angle_align}, 16'h0000);
        clk_en = 1'b1;
        step(1);
        chk({14'h0, grid_ref_sel, angle_align}, 16'h0003);
        fb.send(16'h0000);
        step(1);
        chk({15'h0, grid_ref_sel}, 16'h0000);
    endtask
    // Edge modes: held levels must not change over or release
    task automatic t_single;
        meas = lsf_meas_t'(6'h38);
        fb.send(16'h0023);
        step(1);
        chk({15'h0, grid_ref_sel}, 16'h0001);
        step(1);
        chk({15'h0, line_relay_drive}, 16'h0000);
        fb.send(16'h0021);
        step(1);
        fb.send(16'h0067);
        step(1);
        chk({15'h0, line_relay_drive}, 16'h0001);
        step(1);
        chk({15'h0, line_relay_drive}, 16'h0001);
        fb.send(16'h0063);
        step(1);
        fb.send(16'h0067);
        step(1);
        chk({15'h0, line_relay_drive}, 16'h0000);
        fb.send(16'h0000);
        step(2);
    endtask
    // Sequence mode with single start waits for a start edge
    task automatic t_seq;
        meas = lsf_meas_t'(6'h38);
        fb.send(16'h0211);
        step(1);
        fb.send(16'h0213);
        step(1);
        fb.send(16'h0211);
        step(1);
        chk({15'h0, start_edge_req}, 16'h0001);
        meas = lsf_meas_t'(6'h30);
        step(1);
        meas = lsf_meas_t'(6'h38);
        step(1);
        chk({12'h0, start_edge_req, motor_sel}, 16'h0006);
        fb.send(16'h0000);
        step(1);
    endtask
    // Mid-run reset with the line contactor closed
    task automatic t_reset;
        rst_n = 1'b0;
        step(1);
        chk({11'h0, line_relay_drive, converter_relay_drive, motor_sel},
            16'h0000);
        rst_n = 1'b1;
        step(1);
        chk({15'h0, converter_relay_drive}, 16'h0001);
    endtask
    // Angle kept out first so the changeover is refused once
    task automatic go_online;
        meas = lsf_meas_t'(6'h28);
        fb.send(16'h0001);
        step(1);
        fb.send(16'h0003);
        step(1);
        chk({15'h0, line_relay_drive}, 16'h0000);
        meas = lsf_meas_t'(6'h38);
        step(1);
        chk({13'h0, line_relay_drive, converter_relay_drive, close_line_cmd},
            16'h0005);
        step(1);
        chk(sync_status_word & 16'h01FC, 16'h01BC);
    endtask
    task automatic t_return;
        go_online;
        meas = lsf_meas_t'(6'h3C);
        fb.send(16'h0005);
        step(1);
        chk({15'h0, grid_ref_sel}, 16'h0001);
        fb.finish_return;
        chk({14'h0, converter_relay_drive, line_relay_drive},
            16'h0002);
        step(2);
        chk({15'h0, grid_ref_sel}, 16'h0000);
    endtask
    task automatic t_coast;
        go_online;
        meas = lsf_meas_t'(6'h38);
        fb.send(16'h0005);
        step(1);
        chk({15'h0, line_relay_drive}, 16'h0000);
        step(1);
        chk({15'h0, flying_start}, 16'h0001);
        fb.send(16'h0000);
        step(2);
    endtask
    task automatic t_motor;
        fb.send(16'h5300);
        step(2);
        chk({13'h0, motor_sel}, 16'h0005);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is under a hundred cycles
    initial begin
        #200000;
        miscompares++;
        print_verdict;
    end
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        drive = lsf_drive_t'(11'h5A5);
        meas = lsf_meas_t'(6'h28);
        miscompares = 0;
        num_checks = 0;
        step(4);
        rst_n = 1'b1;
        step(1);
        chk({15'h0, converter_relay_drive}, 16'h0001);
        t_status;
        t_drop;
        t_freeze;
        t_return;
        t_coast;
        t_motor;
        t_single;
        t_seq;
        t_reset;
        print_verdict;
    end
endmodule

// >>> dv/lsf_fieldbus_master.sv
// Fieldbus master model writing the sync control word.
// Assumes its tasks are called just after a falling clock edge.
`timescale 1ns/100ps
module lsf_fieldbus_master (
    // Clock and status in
    input  wire logic        clk,
    input  wire logic [15:0] sync_status_word,
    // Words out
    output logic      [15:0] sync_control_word,
    output logic      [7:0]  status_select_param
);
    initial begin
        sync_control_word   = 16'h0000;
        status_select_param = 8'h41;
    end
    // Pick mode wins, sequence bit dropped
    task automatic send(input logic [15:0] w);
        sync_control_word = w[8] ? (w & 16'hFDFF) : w;
    endtask
    task automatic select(input logic [7:0] s);
        status_select_param = s;
    endtask
    // Hold release and sync until converter relay shows, bounded wait
    task automatic finish_return;
        for (int i = 0; i < 20 && !sync_status_word[6]; i++) begin
            @(negedge clk);
        end
        sync_control_word = 16'h0000;
    endtask
endmodule

// >>> dv/lsf_word_engine_assertions.sv
// Port checks for the line sync word engine.
// Assumes lsf_pkg is compiled; bound to every lsf_word_engine.
`timescale 1ns/100ps
module lsf_word_checker
    import lsf_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    // Words and drive side
    input wire logic [15:0] sync_control_word,
    input wire logic [7:0]  status_select_param,
    input wire logic [15:0] main_drive_status,
    input wire logic [15:0] sync_status_word,
    input wire logic        main_status_valid,
    input wire lsf_drive_t  drive,
    input wire lsf_meas_t   meas,
    // Sequencer outputs
    input wire logic        grid_ref_sel,
    input wire logic        angle_align,
    input wire logic        close_line_cmd,
    input wire logic        converter_relay_drive,
    input wire logic        line_relay_drive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_MAIN_LOW: assert property (
        clk_en |=> main_drive_status[4:0] == $past({drive.warning,
        drive.fault, drive.ccw, drive.run, drive.ready}))
        else $error("main status low bits wrong");
    AST_MAIN_HIGH: assert property (
        clk_en |=> main_drive_status[10:5] ==
        $past({drive.undervoltage_quick_halt_off, drive.enc_ccw,
        drive.torque_ctrl_speed_limit_off, drive.flux_ready,
        drive.zero_speed, drive.at_ref}))
        else $error("main status high bits wrong");
    AST_SELECT: assert property (
        clk_en |=> main_status_valid ==
        ($past(status_select_param) == 8'h40))
        else $error("main status select wrong");
    AST_UNUSED: assert property (
        main_drive_status[15:11] == 5'h00 &&
        sync_status_word[15:13] == 3'h0 && sync_status_word[11:9] == 3'h0)
        else $error("unused status bits set");
    AST_SYNC_CMD: assert property (
        clk_en |=> sync_status_word[2] == $past(sync_control_word[0]) &&
        sync_status_word[12] == $past(meas.start_cmd))
        else $error("sync status command bits wrong");
    AST_MEAS_BITS: assert property (
        clk_en |=> sync_status_word[5:3] == $past({sync_control_word[1],
        meas.angle_in_hyst, meas.freq_in_hyst}))
        else $error("sync status measure bits wrong");
    AST_RELAY_BITS: assert property (
        clk_en |=> sync_status_word[8:6] == $past({line_relay_drive,
        close_line_cmd, converter_relay_drive}))
        else $error("sync status relay bits wrong");
    AST_CHANGEOVER: assert property (
        $rose(line_relay_drive) |->
        close_line_cmd && $past(sync_control_word[1:0]) == 2'h3 &&
        $past(meas.freq_in_hyst && meas.angle_in_hyst))
        else $error("changeover without cause");
    AST_ALIGN: assert property (
        $rose(grid_ref_sel) |-> angle_align && $past(sync_control_word[0]))
        else $error("grid reference without sync");
    AST_RELEASE: assert property (
        $fell(line_relay_drive) |-> $past(sync_control_word[2]))
        else $error("line opened without release");
endmodule
bind lsf_word_engine lsf_word_checker u_chk (.clk, .rst_n, .clk_en,
    .sync_control_word, .status_select_param, .main_drive_status,
    .sync_status_word, .main_status_valid, .drive, .meas, .grid_ref_sel,
    .angle_align, .close_line_cmd, .converter_relay_drive, .line_relay_drive);

// >>> rtl/lsf_pkg.sv
// Types for the line sync fieldbus word interpreter.
// Assumes lsf_regs.svh sits on the include path.
package lsf_pkg;
    typedef struct packed {
        logic ready;
        logic run;
        logic ccw;
        logic fault;
        logic warning;
        logic at_ref;
        logic zero_speed;
        logic flux_ready;
        logic torque_ctrl_speed_limit_off;
        logic enc_ccw;
        logic undervoltage_quick_halt_off;
    } lsf_drive_t;

    typedef struct packed {
        logic freq_in_hyst;
        logic angle_in_hyst;
        logic start_cmd;
        logic return_sync_enable;
        logic line_closed;
        logic converter_closed;
    } lsf_meas_t;

    typedef enum logic [4:0] {
        LSF_NORMAL  = 5'b00001,
        LSF_SYNCING = 5'b00010,
        LSF_ONLINE  = 5'b00100,
        LSF_RETURN  = 5'b01000,
        LSF_COAST   = 5'b10000
    } lsf_state_t;
endpackage

// >>> rtl/lsf_regs.svh
// Bit positions and codes for the line sync fieldbus words.
// Assumes inclusion by bare name from the design module.
`ifndef LSF_REGS_SVH
`define LSF_REGS_SVH
// Control word bits
`define LSF_CW_SYNC       0
`define LSF_CW_TRANSFER   1
`define LSF_CW_RELEASE    2
`define LSF_CW_SGL_START  4
`define LSF_CW_SGL_NET    5
`define LSF_CW_SGL_RESET  6
`define LSF_CW_PICK       8
`define LSF_CW_SEQ        9
`define LSF_CW_MSEL_LO    12
`define LSF_CW_MSEL_HI    14
// Selector codes
`define LSF_SEL_MAIN      8'h40
`define LSF_SEL_DEFAULT   8'h41
// Sync status bits
`define LSF_SS_READY      0
`define LSF_SS_RUN        1
`define LSF_SS_SYNC       2
`define LSF_SS_FREQ       3
`define LSF_SS_ANGLE      4
`define LSF_SS_DIRECT     5
`define LSF_SS_CONV       6
`define LSF_SS_CLOSE      7
`define LSF_SS_LINE       8
`define LSF_SS_START      12
// Motor count
`define LSF_MOTOR_MAX     3'h7
`define LSF_MOTOR_FIRST   3'h0
`define LSF_MOTOR_STEP    3'h1
// Main status bits
`define LSF_MS_READY      0
`define LSF_MS_RUN        1
`define LSF_MS_CCW        2
`define LSF_MS_FAULT      3
`define LSF_MS_WARN       4
`define LSF_MS_ATREF      5
`define LSF_MS_ZERO       6
`define LSF_MS_FLUX       7
`define LSF_MS_LIMIT      8
`define LSF_MS_ENC        9
`define LSF_MS_UVHALT     10
`define LSF_WORD_ZERO     16'h0000
`endif

// >>> rtl/lsf_word_engine.sv
// Line sync control word decoder and status word builder.
// Assumes all inputs synchronous to clk; measurements come from elsewhere.
`timescale 1ns/100ps
`include "lsf_regs.svh"

// Overview of operation
// - Main status bits 0-4: ready, run, ccw, fault, warning.
// - Main status bits 5-10: at ref, zero speed, flux, limits, encoder, undervoltage quick halt.
// - Main status word is always output; valid flag set only when selector equals 64.
// - Control bit 0 selects grid frequency reference and angle alignment.
// - Control bit 1 changes over only with bit 0 and sync reached.
// - Control bit 2 opens line contactors, then coast or restart.
// - Return sync needs enable, start and sync commands; else flying start.
// - Return sync starts at grid frequency, aligns, swaps contactors.
// - After converter control, clearing bits 2 and 0 gives normal ref.
// - Bit 4 requires rising start edge for each next motor.
// - Bit 5 requires rising edges for sync and changeover.
// - Bit 6 makes each release edge open only one line contactor.
// - Bit 8 selects motor from control bits 12 to 14.
// - Bit 9 moves all motors in turn; never with bit 8.
// - Sync status bits 0,1,2,12: ready, run, sync command, start.
// - Sync status bit 3: output within 0.10 Hz of grid.
// - Sync status bit 4 angle in hysteresis, bit 5 changeover command.
// - Sync status bits 6,7,8 mirror converter, close and line drives.
module lsf_word_engine
    import lsf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Fieldbus words
    input  wire logic [15:0] sync_control_word,
    input  wire logic [7:0]  status_select_param,
    output logic      [15:0] main_drive_status,
    output logic      [15:0] sync_status_word,
    output logic             main_status_valid,
    // Drive and measurement side
    input  wire lsf_drive_t  drive,
    input  wire lsf_meas_t   meas,
    // Sequencer outputs
    output logic             grid_ref_sel,
    output logic             angle_align,
    output logic             close_line_cmd,
    output logic             converter_relay_drive,
    output logic             line_relay_drive,
    output logic             flying_start,
    output logic             start_edge_req,
    output logic      [2:0]  motor_sel
);
    // Sequencer state
    lsf_state_t  st_q, st_d;
    logic        conv_q, conv_d;
    logic        line_q, line_d;
    logic        clos_q, clos_d;
    logic        fly_q, fly_d;
    logic        sreq_q, sreq_d;
    logic        seq_adv;
    // Edge history
    logic [15:0] cw_q, cw_d;
    logic        start_q, start_d;
    // Motor selection
    logic [2:0]  mot_q, mot_d;
    // Status words
    logic [15:0] ms_q, ms_d;
    logic        msv_q, msv_d;
    logic [15:0] ss_q, ss_d;
    // Reference drives
    logic        grid_q, grid_d;
    logic        align_q, align_d;
    // Decoded commands
    logic        sync_b, xfer_b, rel_b;
    logic        sync_rise, xfer_rise, rel_rise;
    logic        start_rise, sync_ok, go_sync, go_xfer;

    always_comb begin
        // Only documented control bits are decoded
        sync_b     = sync_control_word[`LSF_CW_SYNC];
        xfer_b     = sync_control_word[`LSF_CW_TRANSFER];
        rel_b      = sync_control_word[`LSF_CW_RELEASE];
        sync_rise  = sync_b & ~cw_q[`LSF_CW_SYNC];
        xfer_rise  = xfer_b & ~cw_q[`LSF_CW_TRANSFER];
        rel_rise   = rel_b & ~cw_q[`LSF_CW_RELEASE];
        start_rise = meas.start_cmd & ~start_q;
        sync_ok    = meas.freq_in_hyst & meas.angle_in_hyst;
        // Edge-only mode stops level retriggering
        go_sync = sync_control_word[`LSF_CW_SGL_NET] ? sync_rise : sync_b;
        go_xfer = sync_control_word[`LSF_CW_SGL_NET] ? xfer_rise : xfer_b;
        // Levels hold; the two pulses clear on every enabled cycle
        st_d    = st_q;
        conv_d  = conv_q;
        line_d  = line_q;
        clos_d  = 1'b0;
        fly_d   = 1'b0;
        sreq_d  = sreq_q;
        seq_adv = 1'b0;
        unique case (st_q)
            LSF_NORMAL: begin
                conv_d = 1'b1;
                if (go_sync && !line_q) begin
                    st_d = LSF_SYNCING;
                end
                if (rel_b && line_q) begin
                    st_d = LSF_COAST;
                end
            end

            LSF_SYNCING: begin
                if (!sync_b) begin
                    st_d = LSF_NORMAL; // Dropped early
                end else if (go_xfer && sync_ok) begin
                    st_d   = LSF_ONLINE;
                    clos_d = 1'b1;
                    line_d = 1'b1;
                    conv_d = 1'b0;
                end
            end

            LSF_ONLINE: begin
                // Next motor in turn; edge start mode waits for edge
                if (sync_control_word[`LSF_CW_SEQ] &&
                    !sync_control_word[`LSF_CW_PICK] &&
                    mot_q != `LSF_MOTOR_MAX && !xfer_b) begin
                    if (!sync_control_word[`LSF_CW_SGL_START]
                        || start_rise) begin
                        seq_adv = 1'b1;
                        st_d   = LSF_NORMAL;
                        sreq_d = 1'b0;
                    end else begin
                        sreq_d = 1'b1;
                    end
                end
                // One contactor per release edge
                if (sync_control_word[`LSF_CW_SGL_RESET] ? rel_rise
                                                          : rel_b) begin
                    if (meas.return_sync_enable && meas.start_cmd &&
                        sync_b) begin
                        st_d = LSF_RETURN;
                    end else begin
                        st_d   = LSF_COAST;
                        line_d = 1'b0;
                    end
                end
            end

            LSF_RETURN: begin
                // Release bit must stay up until handback
                if (!rel_b || !sync_b) begin
                    st_d   = LSF_COAST;
                    line_d = 1'b0;
                end else if (sync_ok) begin
                    conv_d = 1'b1; // Contactor swap
                    line_d = 1'b0;
                    st_d   = LSF_NORMAL;
                end
            end

            LSF_COAST: begin
                line_d = 1'b0;
                fly_d  = 1'b1; // Flying start
                st_d   = LSF_NORMAL;
            end
        endcase
    end

    // Frozen while clk_en low; outputs lag the decision one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= LSF_NORMAL;
            conv_q <= 1'b0;
            line_q <= 1'b0;
            clos_q <= 1'b0;
            fly_q  <= 1'b0;
            sreq_q <= 1'b0;
        end else if (clk_en) begin
            st_q   <= st_d;
            conv_q <= conv_d;
            line_q <= line_d;
            clos_q <= clos_d;
            fly_q  <= fly_d;
            sreq_q <= sreq_d;
        end
    end

    // Grid reference and angle alignment follow the next state
    always_comb begin
        grid_d  = (st_d == LSF_SYNCING) || (st_d == LSF_RETURN);
        align_d = (st_d == LSF_SYNCING) || (st_d == LSF_RETURN);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grid_q  <= 1'b0;
            align_q <= 1'b0;
        end else if (clk_en) begin
            grid_q  <= grid_d;
            align_q <= align_d;
        end
    end

    // Previous control word and start command for edge detection
    always_comb begin
        cw_d    = sync_control_word;
        start_d = meas.start_cmd;
    end

    // History clears to the idle word so no false edge follows reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cw_q    <= `LSF_WORD_ZERO;
            start_q <= 1'b0;
        end else if (clk_en) begin
            cw_q    <= cw_d;
            start_q <= start_d;
        end
    end

    // Explicit pick wins; sequencing is ignored when both are set
    always_comb begin
        mot_d = mot_q;
        if (sync_control_word[`LSF_CW_PICK]) begin
            mot_d = sync_control_word[`LSF_CW_MSEL_HI:`LSF_CW_MSEL_LO];
        end else if (seq_adv) begin
            // Sequencer stops at the last motor, so no wrap here
            mot_d = 3'(mot_q + `LSF_MOTOR_STEP);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mot_q <= `LSF_MOTOR_FIRST;
        end else if (clk_en) begin
            mot_q <= mot_d;
        end
    end

    // Main status word; bits above the last field stay zero
    always_comb begin
        ms_d = `LSF_WORD_ZERO;
        ms_d[`LSF_MS_READY]  = drive.ready;
        ms_d[`LSF_MS_RUN]    = drive.run;
        ms_d[`LSF_MS_CCW]    = drive.ccw;
        ms_d[`LSF_MS_FAULT]  = drive.fault;
        ms_d[`LSF_MS_WARN]   = drive.warning;
        ms_d[`LSF_MS_ATREF]  = drive.at_ref;
        ms_d[`LSF_MS_ZERO]   = drive.zero_speed;
        ms_d[`LSF_MS_FLUX]   = drive.flux_ready;
        ms_d[`LSF_MS_LIMIT]  = drive.torque_ctrl_speed_limit_off;
        ms_d[`LSF_MS_ENC]    = drive.enc_ccw;
        ms_d[`LSF_MS_UVHALT] = drive.undervoltage_quick_halt_off;
        // Word is built always; the flag tells the master which it reads
        msv_d = (status_select_param == `LSF_SEL_MAIN);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_q  <= `LSF_WORD_ZERO;
            msv_q <= 1'b0;
        end else if (clk_en) begin
            ms_q  <= ms_d;
            msv_q <= msv_d;
        end
    end

    // Sync status word, unassigned bits zero
    always_comb begin
        ss_d = `LSF_WORD_ZERO;
        ss_d[`LSF_SS_READY]  = drive.ready;
        ss_d[`LSF_SS_RUN]    = drive.run;
        ss_d[`LSF_SS_SYNC]   = sync_b;
        ss_d[`LSF_SS_START]  = meas.start_cmd;
        ss_d[`LSF_SS_FREQ]   = meas.freq_in_hyst;
        ss_d[`LSF_SS_ANGLE]  = meas.angle_in_hyst;
        ss_d[`LSF_SS_DIRECT] = xfer_b;
        ss_d[`LSF_SS_CONV]   = conv_q;
        ss_d[`LSF_SS_CLOSE]  = clos_q;
        ss_d[`LSF_SS_LINE]   = line_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ss_q <= `LSF_WORD_ZERO;
        end else if (clk_en) begin
            ss_q <= ss_d;
        end
    end

    assign main_drive_status     = ms_q;
    assign main_status_valid     = msv_q;
    assign sync_status_word      = ss_q;
    assign grid_ref_sel          = grid_q;
    assign angle_align           = align_q;
    assign close_line_cmd        = clos_q;
    assign converter_relay_drive = conv_q;
    assign line_relay_drive      = line_q;
    assign flying_start          = fly_q;
    assign start_edge_req        = sreq_q;
    assign motor_sel             = mot_q;
endmodule
